// ---- hdl/usb_status_interrupt_logic.v ----
// Contract
// - Flags at bits 6..0, bit 7 zero, reset clear.
// - Stall handshake sent sets bit 5.
// - Bus idle 3 ms or more sets bit 4.
// - Transaction done sets bit 3, status readable.
// - Activity on data lines sets bit 2.
// - Error summary is read-only, from enabled errors.
// - Bus reset sets bit 0, reloads address.
// - Clearing transaction done advances status FIFO.
// - Activity clear ignored while suspended or waking.
// - Module may wait for PLL lock.
// - Activity flag raised once per resume.
// - Activity re-armed only after new idle.
// - Mask bit enables matching flag onto request.
// - Flags set regardless of mask bits.
// - Flags other than error summary sticky until written zero; one sets.
// - Request is OR of masked flags.
// - While suspended only activity is detected.
// - Mask mirrors flags, bit 7 zero, reset clear.
`include "usb_event_defines.vh"

module usb_status_interrupt_logic #(
   parameter IDLE_CYCLES = `IDLE_TIME_US * `CLOCK_MHZ,
   parameter FIFO_DEPTH_LOG2 = 2
)(
   input wire REF_CLK,
   input wire RSTN,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   input wire FRAME_START_TOKEN,
   input wire STALL_SENT,
   input wire TRANSACTION_DONE,
   input wire [7:0] TRANSACTION_INFO,
   input wire BUS_ERROR_VALID,
   input wire [7:0] BUS_ERROR_BITS,
   input wire BUS_RESET_DETECT,
   input wire LINE_DP,
   input wire LINE_DM,
   input wire PLL_LOCKED,
   output reg PERIPHERAL_IRQ_REQUEST,
   output reg SUSPEND_ACTIVE,
   output reg ENGINE_READY,
   output reg [6:0] DEVICE_ADDRESS
);
   ////////////////////////////////////////////////////////////////////////
   localparam ST_RUN = 3'b001;
   localparam ST_SUSPENDED = 3'b010;
   localparam ST_WAKING = 3'b100;

   reg [1:0] dp_sync;
   reg [1:0] dm_sync;
   reg [1:0] dp_line;
   reg [1:0] dm_line;
   reg [`FLAG_WIDTH-1:0] usb_event_flags;
   reg [`FLAG_WIDTH-1:0] usb_event_mask;
   reg [7:0] error_event_flags;
   reg [7:0] error_event_mask;
   reg [7:0] usb_control_reg;
   reg [31:0] idle_count;
   reg idle_reported;
   reg activity_armed;
   reg [2:0] state;
   reg [2:0] next_state;
   reg [3:0] wake_count;
   reg [`FLAG_WIDTH-1:0] next_flags;
   reg [7:0] next_errors;
   wire wr_access;
   wire rd_access;
   wire [7:0] fifo_head;
   wire fifo_not_empty;
   wire engine_on;
   wire bus_idle;
   wire bus_activity;
   wire activity_clear_allowed;
   wire flags_write;
   wire trans_done_clear;
   wire address_write;
   wire mask_write;
   wire control_write;
   wire error_flags_write;
   wire error_mask_write;
   wire idle_event;

   // Keeps the decoding of a register address in one place.
   function hit;
      input [11:0] addr;
      input [11:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   // The event fires one count early so that the flag lands on the full idle time.
   function idle_due;
      input [31:0] count;
      begin
         idle_due = (count >= IDLE_CYCLES - 1);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pins from the transceiver are asynchronous: three flops before any use.
   always @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         // Reset to the idle J level, so that release does not look like bus activity.
         dp_sync <= 2'h3;
         dm_sync <= 2'h0;
         dp_line <= 2'h3;
         dm_line <= 2'h0;
      end
      else
      begin
         dp_sync <= {dp_sync[0], LINE_DP};
         dm_sync <= {dm_sync[0], LINE_DM};
         dp_line <= {dp_line[0], dp_sync[1]};
         dm_line <= {dm_line[0], dm_sync[1]};
      end
   end

   // A full-speed idle bus is J: D+ high, D- low.
   assign bus_idle = dp_line[0] && !dm_line[0];
   assign bus_activity = (dp_line[0] != dp_line[1]) || (dm_line[0] != dm_line[1]);

   ////////////////////////////////////////////////////////////////////////
   assign wr_access = PSEL && PENABLE && PWRITE && PREADY;
   assign rd_access = PSEL && !PENABLE && !PWRITE;
   assign flags_write = wr_access && hit(PADDR, `ADDR_EVENT_FLAGS);
   assign address_write = wr_access && hit(PADDR, `ADDR_DEVICE_ADDRESS);
   assign mask_write = wr_access && hit(PADDR, `ADDR_EVENT_MASK);
   assign control_write = wr_access && hit(PADDR, `ADDR_CONTROL);
   assign error_flags_write = wr_access && hit(PADDR, `ADDR_ERROR_FLAGS);
   assign error_mask_write = wr_access && hit(PADDR, `ADDR_ERROR_MASK);
   assign trans_done_clear = flags_write && usb_event_flags[`BIT_TRANS_DONE] &&
                             !PWDATA[`BIT_TRANS_DONE];
   assign engine_on = (state == ST_RUN) && ENGINE_READY;
   assign activity_clear_allowed = (state == ST_RUN);
   assign idle_event = engine_on && bus_idle && !idle_reported && idle_due(idle_count);

   // The FIFO push is gated by engine_on: nothing arrives in suspend.
   usb_status_fifo #(
      .WIDTH(8),
      .DEPTH_LOG2(FIFO_DEPTH_LOG2)
   ) u_transaction_status_fifo (
      .clk(REF_CLK),
      .rst_n(RSTN),
      .push(TRANSACTION_DONE && engine_on),
      .push_data(TRANSACTION_INFO),
      .pop(trans_done_clear),
      .head(fifo_head),
      .not_empty(fifo_not_empty),
      .full()
   );

   ////////////////////////////////////////////////////////////////////////
   // Suspend control, wake synchronisation and PLL lock wait.
   always @*
   begin
      next_state = state;
      case (state)
         ST_RUN:
            if (usb_control_reg[`BIT_SUSPEND])
               next_state = ST_SUSPENDED;
         ST_SUSPENDED:
            if (!usb_control_reg[`BIT_SUSPEND])
               next_state = ST_WAKING;
         ST_WAKING:
            if (usb_control_reg[`BIT_SUSPEND])
               next_state = ST_SUSPENDED;
            else if (wake_count == `WAKE_SYNC_CYCLES && PLL_LOCKED)
               next_state = ST_RUN;
         default:
            next_state = ST_RUN;
      endcase
   end

   always @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         state <= ST_RUN;
         wake_count <= 4'h0;
         ENGINE_READY <= 1'b0;
         SUSPEND_ACTIVE <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (state == ST_WAKING && wake_count != `WAKE_SYNC_CYCLES)
            wake_count <= wake_count + 4'h1;
         else if (state != ST_WAKING)
            wake_count <= 4'h0;
         ENGINE_READY <= (next_state == ST_RUN) && PLL_LOCKED;
         SUSPEND_ACTIVE <= (next_state == ST_SUSPENDED);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Idle timer and the once-per-resume arming of the activity flag.
   always @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         idle_count <= 32'h0;
         idle_reported <= 1'b0;
         activity_armed <= 1'b0;
      end
      else
      begin
         if (!bus_idle || bus_activity)
         begin
            idle_count <= 32'h0;
            idle_reported <= 1'b0;
         end
         else if (idle_count < IDLE_CYCLES)
            idle_count <= idle_count + 32'h1;
         if (idle_event)
         begin
            idle_reported <= 1'b1;
            activity_armed <= 1'b1;
         end
         else if (activity_armed && bus_activity)
            activity_armed <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flag update: software write first, hardware set wins over a clear except for transaction done.
   always @*
   begin
      next_flags = usb_event_flags;
      next_errors = error_event_flags;
      if (flags_write)
      begin
         next_flags = PWDATA[`FLAG_WIDTH-1:0];
         next_flags[`BIT_ERROR_SUMMARY] = usb_event_flags[`BIT_ERROR_SUMMARY];
         if (!activity_clear_allowed)
            next_flags[`BIT_BUS_ACTIVITY] = usb_event_flags[`BIT_BUS_ACTIVITY];
      end
      if (error_flags_write)
         next_errors = error_event_flags & PWDATA[7:0];
      if (engine_on && BUS_ERROR_VALID)
         next_errors = next_errors | BUS_ERROR_BITS;
      // Flags set regardless of the mask bits so that polling works.
      if (engine_on && FRAME_START_TOKEN)
         next_flags[`BIT_FRAME_START] = 1'b1;
      if (engine_on && STALL_SENT)
         next_flags[`BIT_STALL_SENT] = 1'b1;
      if (idle_event)
         next_flags[`BIT_BUS_IDLE] = 1'b1;
      // A clear pops one entry and drops the flag for that cycle; the flag
      // comes back on the next cycle while further entries remain.
      if (fifo_not_empty && !trans_done_clear)
         next_flags[`BIT_TRANS_DONE] = 1'b1;
      if (activity_armed && bus_activity)
         next_flags[`BIT_BUS_ACTIVITY] = 1'b1;
      next_flags[`BIT_ERROR_SUMMARY] = |(next_errors & error_event_mask);
      if (engine_on && BUS_RESET_DETECT)
         next_flags[`BIT_BUS_RESET] = 1'b1;
   end

   always @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         usb_event_flags <= `FLAGS_RESET;
         usb_event_mask <= `MASK_RESET;
         error_event_flags <= `ERROR_RESET;
         error_event_mask <= `ERROR_RESET;
         usb_control_reg <= 8'h00;
         DEVICE_ADDRESS <= `ADDRESS_DEFAULT;
         PERIPHERAL_IRQ_REQUEST <= 1'b0;
      end
      else
      begin
         usb_event_flags <= next_flags;
         error_event_flags <= next_errors;
         if (mask_write)
            usb_event_mask <= PWDATA[`FLAG_WIDTH-1:0];
         if (error_mask_write)
            error_event_mask <= PWDATA[7:0];
         if (control_write)
            usb_control_reg <= PWDATA[7:0];
         if (engine_on && BUS_RESET_DETECT)
            DEVICE_ADDRESS <= `ADDRESS_DEFAULT;
         else if (address_write)
            DEVICE_ADDRESS <= PWDATA[6:0];
         PERIPHERAL_IRQ_REQUEST <= |(next_flags & usb_event_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave: no wait states, read data captured in the setup cycle.
   always @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         PRDATA <= 32'h0;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end
      else
      begin
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= 1'b0;
         if (PSEL && !PENABLE)
         begin
            PSLVERR <= !(hit(PADDR, `ADDR_EVENT_FLAGS) || hit(PADDR, `ADDR_EVENT_MASK) ||
                         hit(PADDR, `ADDR_CONTROL) || hit(PADDR, `ADDR_TRANS_STATUS) ||
                         hit(PADDR, `ADDR_DEVICE_ADDRESS) || hit(PADDR, `ADDR_ERROR_FLAGS) ||
                         hit(PADDR, `ADDR_ERROR_MASK));
         end
         if (rd_access)
         begin
            PRDATA <= 32'h0;
            if (hit(PADDR, `ADDR_EVENT_FLAGS))
               PRDATA <= {25'h0, usb_event_flags};
            else if (hit(PADDR, `ADDR_EVENT_MASK))
               PRDATA <= {25'h0, usb_event_mask};
            else if (hit(PADDR, `ADDR_CONTROL))
               PRDATA <= {24'h0, usb_control_reg};
            else if (hit(PADDR, `ADDR_TRANS_STATUS))
               PRDATA <= {24'h0, fifo_head};
            else if (hit(PADDR, `ADDR_DEVICE_ADDRESS))
               PRDATA <= {25'h0, DEVICE_ADDRESS};
            else if (hit(PADDR, `ADDR_ERROR_FLAGS))
               PRDATA <= {24'h0, error_event_flags};
            else if (hit(PADDR, `ADDR_ERROR_MASK))
               PRDATA <= {24'h0, error_event_mask};
         end
      end
   end
endmodule

// ---- pkg/usb_event_defines.vh ----
`ifndef USB_EVENT_DEFINES_VH
`define USB_EVENT_DEFINES_VH

// Register byte addresses on the APB bus.
`define ADDR_EVENT_FLAGS 12'h000
`define ADDR_EVENT_MASK 12'h004
`define ADDR_CONTROL 12'h008
`define ADDR_TRANS_STATUS 12'h00C
`define ADDR_DEVICE_ADDRESS 12'h010
`define ADDR_ERROR_FLAGS 12'h014
`define ADDR_ERROR_MASK 12'h018

// Event flag positions, shared by the flag and mask registers.
`define BIT_FRAME_START 6
`define BIT_STALL_SENT 5
`define BIT_BUS_IDLE 4
`define BIT_TRANS_DONE 3
`define BIT_BUS_ACTIVITY 2
`define BIT_ERROR_SUMMARY 1
`define BIT_BUS_RESET 0
`define FLAG_WIDTH 7

// Control register fields.
`define BIT_SUSPEND 1

// Reset values.
`define FLAGS_RESET 7'h00
`define MASK_RESET 7'h00
`define ERROR_RESET 8'h00
`define ADDRESS_DEFAULT 7'h00

// Idle time before the idle flag is raised, and the clock rate.
`define IDLE_TIME_US 3000
`define CLOCK_MHZ 250

// Cycles after wake during which an activity clear is not honoured.
`define WAKE_SYNC_CYCLES 4'h8

`endif

// ---- hdl/usb_status_fifo.v ----
`include "usb_event_defines.vh"

module usb_status_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH_LOG2 = 2
)(
   input wire clk,
   input wire rst_n,
   input wire push,
   input wire [WIDTH-1:0] push_data,
   input wire pop,
   output wire [WIDTH-1:0] head,
   output wire not_empty,
   output wire full
);
   localparam DEPTH = 1 << DEPTH_LOG2;

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [DEPTH_LOG2:0] wr_ptr;
   reg [DEPTH_LOG2:0] rd_ptr;
   wire do_push;
   wire do_pop;

   assign not_empty = (wr_ptr != rd_ptr);
   assign full = (wr_ptr[DEPTH_LOG2-1:0] == rd_ptr[DEPTH_LOG2-1:0]) &&
                 (wr_ptr[DEPTH_LOG2] != rd_ptr[DEPTH_LOG2]);
   assign head = mem[rd_ptr[DEPTH_LOG2-1:0]];
   assign do_push = push && !full;
   assign do_pop = pop && not_empty;

   always @(posedge clk)
   begin
      if (do_push)
         mem[wr_ptr[DEPTH_LOG2-1:0]] <= push_data;
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= {(DEPTH_LOG2+1){1'b0}};
         rd_ptr <= {(DEPTH_LOG2+1){1'b0}};
      end
      else
      begin
         if (do_push)
            wr_ptr <= wr_ptr + 1'b1;
         if (do_pop)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule

// ---- tb/host_side_model.sv ----
module host_side_model (
   input wire logic clk,
   input wire logic [4:0] fire,
   input wire logic traffic,
   input wire logic [7:0] info,
   output logic sof,
   output logic stall,
   output logic done,
   output logic brst,
   output logic err,
   output logic [7:0] info_q,
   output logic dp,
   output logic dm
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {sof, stall, done, brst, err} = 5'h00;
      info_q = 8'h00;
      dp = 1'b1;
      dm = 1'b0;
   end
   ////////////////////////////////////////////////////////////
   // Outside a report the side data is inverted each cycle, so stale data never looks valid.
   always @(posedge clk)
   begin
      {sof, stall, done, brst, err} <= fire;
      info_q <= (fire[2] | fire[0]) ? info : ~info_q;
      dp <= traffic ? ~dp : 1'b1;
      dm <= traffic ? dp : 1'b0;
   end
endmodule

// ---- tb/usb_status_interrupt_logic_chk.sv ----
module usb_status_interrupt_logic_chk (
   input wire REF_CLK,
   input wire RSTN,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [31:0] PRDATA,
   input wire PREADY,
   input wire PSLVERR,
   input wire BUS_RESET_DETECT,
   input wire PLL_LOCKED,
   input wire PERIPHERAL_IRQ_REQUEST,
   input wire SUSPEND_ACTIVE,
   input wire ENGINE_READY,
   input wire [6:0] DEVICE_ADDRESS
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RSTN);
   wire rd = PREADY && !PWRITE && !PSLVERR;
   wire wr = PSEL && PENABLE && PREADY && PWRITE;
   AST_READY: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready after setup");
   AST_ONE: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   AST_FLAGS_TOP: assert property (rd && PADDR == 12'h000 |-> PRDATA[31:7] == 25'h0000000)
      else $error("flag upper bits set");
   AST_MASK_TOP: assert property (rd && PADDR == 12'h004 |-> PRDATA[31:7] == 25'h0000000)
      else $error("mask upper bits set");
   AST_UNMAPPED: assert property (PREADY && (PADDR > 12'h018 || PADDR[1:0] != 2'h0)
      |-> PSLVERR && (PWRITE || PRDATA == 32'h00000000))
      else $error("unmapped access not refused");
   AST_ADDR_RELOAD: assert property (BUS_RESET_DETECT && ENGINE_READY
      |=> DEVICE_ADDRESS == 7'h00)
      else $error("address not reloaded");
   AST_MASK_OFF: assert property (wr && PADDR == 12'h004 && PWDATA[6:0] == 7'h00
      |-> ##2 !PERIPHERAL_IRQ_REQUEST)
      else $error("request without enable");
   AST_STICKY: assert property (PERIPHERAL_IRQ_REQUEST && !(PSEL && PWRITE) && !$past(PSEL)
      |=> PERIPHERAL_IRQ_REQUEST)
      else $error("request dropped without write");
   AST_PLL: assert property (!PLL_LOCKED |=> !ENGINE_READY)
      else $error("ready without lock");
   AST_WAKE: assert property ($fell(SUSPEND_ACTIVE) |-> !ENGINE_READY [*8])
      else $error("ready too soon after wake");
   cover property (wr && PADDR == 12'h008);
   cover property (PREADY && PSLVERR);
   cover property ($rose(PERIPHERAL_IRQ_REQUEST));
endmodule

// ---- tb/test_usb_status_interrupt_logic.sv ----
module test_usb_status_interrupt_logic;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int IDLE = 50;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] rdata;
   logic [31:0] lfsr = 32'h00017572;
   logic [4:0] fire = 5'h00;
   logic traffic = 1'b1;
   logic pll = 1'b1;
   logic err_bit;
   logic [7:0] info = 8'h00;
   logic [7:0] ia;
   logic [7:0] ib;
   wire [31:0] prdata;
   wire pready, pslverr, irq, susp, eng_rdy, sof, stall, done, brst, err, dp, dm;
   wire [6:0] dev_addr;
   wire [7:0] info_q;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   int bits [3] = '{6, 5, 0};
   logic [4:0] fires [3] = '{5'h10, 5'h08, 5'h02};
   host_side_model model (.clk(ref_clk), .fire(fire), .traffic(traffic), .info(info),
      .sof(sof), .stall(stall), .done(done), .brst(brst), .err(err), .info_q(info_q),
      .dp(dp), .dm(dm));
   usb_status_interrupt_logic #(.IDLE_CYCLES(IDLE), .FIFO_DEPTH_LOG2(2)) DUT (
      .REF_CLK(ref_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .FRAME_START_TOKEN(sof), .STALL_SENT(stall), .TRANSACTION_DONE(done),
      .TRANSACTION_INFO(info_q), .BUS_ERROR_VALID(err), .BUS_ERROR_BITS(info_q),
      .BUS_RESET_DETECT(brst), .LINE_DP(dp), .LINE_DM(dm), .PLL_LOCKED(pll),
      .PERIPHERAL_IRQ_REQUEST(irq), .SUSPEND_ACTIVE(susp), .ENGINE_READY(eng_rdy),
      .DEVICE_ADDRESS(dev_addr));
   always #2 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] flag_bit(input int b);
      return 32'h00000001 << b;
   endfunction
   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk({31'h00000000, got}, {31'h00000000, exp});
   endtask
   // Entered just after a rising edge; the trailing edge keeps psel from two writes in one step.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      // No local limit: a slave that never answers is caught by the cycle ceiling.
      while (pready !== 1'b1)
         @(posedge ref_clk);
      rdata = prdata;
      err_bit = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(rdata, exp);
   endtask
   task automatic ev(input logic [4:0] f);
      fire <= f;
      @(posedge ref_clk);
      fire <= 5'h00;
      repeat (3) @(posedge ref_clk);
   endtask
   function automatic logic [31:0] lfsr_step(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic rnd;
      lfsr = lfsr_step(lfsr);
   endtask
   ////////////////////////////////////////////////////////////
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         failures++;
         print_verdict();
      end
   end
   initial
   begin
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      rd(12'h000, 32'h00000000);
      rd(12'h004, 32'h00000000);
      apb(1'b0, 12'h01C, 32'h00000000);
      chk(rdata, 32'h00000000);
      chk1(err_bit, 1'b1);
      wr(12'h004, 32'hFFFFFFFF);
      rd(12'h004, 32'h0000007F);
      wr(12'h004, 32'h00000000);
      rnd();
      wr(12'h010, {25'h0000000, lfsr[6:0] | 7'h01});
      rd(12'h010, {25'h0000000, lfsr[6:0] | 7'h01});
      foreach (bits[i])
      begin
         ev(fires[i]);
         rd(12'h000, flag_bit(bits[i]));
         chk1(irq, 1'b0);
         wr(12'h004, flag_bit(bits[i]));
         @(posedge ref_clk);
         chk1(irq, 1'b1);
         wr(12'h004, 32'h00000000);
         wr(12'h000, 32'h00000000);
         rd(12'h000, 32'h00000000);
      end
      chk({25'h0000000, dev_addr}, 32'h00000000);
      rnd();
      ia = lfsr[7:0];
      ib = ~lfsr[15:8];
      info <= ia;
      ev(5'h04);
      info <= ib;
      ev(5'h04);
      rd(12'h000, 32'h00000008);
      rd(12'h00C, {24'h000000, ia});
      wr(12'h000, 32'h00000000);
      rd(12'h000, 32'h00000008);
      rd(12'h00C, {24'h000000, ib});
      wr(12'h000, 32'h00000000);
      rd(12'h000, 32'h00000000);
      info <= lfsr[23:16] | 8'h01;
      ev(5'h01);
      rd(12'h000, 32'h00000000);
      wr(12'h018, 32'h000000FF);
      rd(12'h000, 32'h00000002);
      wr(12'h000, 32'h00000000);
      rd(12'h000, 32'h00000002);
      wr(12'h014, 32'h00000000);
      wr(12'h000, 32'h00000002);
      rd(12'h000, 32'h00000000);
      wr(12'h018, 32'h00000000);
      wr(12'h000, 32'h00000061);
      rd(12'h000, 32'h00000061);
      wr(12'h000, 32'h00000000);
      traffic <= 1'b0;
      repeat (IDLE - 10) @(posedge ref_clk);
      rd(12'h000, 32'h00000000);
      repeat (20) @(posedge ref_clk);
      rd(12'h000, 32'h00000010);
      traffic <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rd(12'h000, 32'h00000014);
      wr(12'h000, 32'h00000000);
      repeat (20) @(posedge ref_clk);
      rd(12'h000, 32'h00000000);
      traffic <= 1'b0;
      repeat (IDLE + 20) @(posedge ref_clk);
      rd(12'h000, 32'h00000010);
      wr(12'h000, 32'h00000000);
      wr(12'h008, 32'h00000002);
      @(posedge ref_clk);
      chk1(susp, 1'b1);
      ev(5'h08);
      rd(12'h000, 32'h00000000);
      traffic <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rd(12'h000, 32'h00000004);
      wr(12'h000, 32'h00000000);
      rd(12'h000, 32'h00000004);
      pll <= 1'b0;
      wr(12'h008, 32'h00000000);
      repeat (12) @(posedge ref_clk);
      chk1(eng_rdy, 1'b0);
      pll <= 1'b1;
      for (int n = 0; n < 40; n++)
      begin
         apb(1'b0, 12'h000, 32'h00000000);
         if (rdata[2] !== 1'b1)
            break;
         wr(12'h000, 32'h00000000);
      end
      chk(rdata, 32'h00000000);
      chk1(eng_rdy, 1'b1);
      wr(12'h004, 32'h0000007F);
      rstn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      rd(12'h004, 32'h00000000);
      print_verdict();
   end
endmodule
bind usb_status_interrupt_logic usb_status_interrupt_logic_chk u_chk (.REF_CLK(REF_CLK),
   .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .BUS_RESET_DETECT(BUS_RESET_DETECT), .PLL_LOCKED(PLL_LOCKED),
   .PERIPHERAL_IRQ_REQUEST(PERIPHERAL_IRQ_REQUEST), .SUSPEND_ACTIVE(SUSPEND_ACTIVE),
   .ENGINE_READY(ENGINE_READY), .DEVICE_ADDRESS(DEVICE_ADDRESS));
